// ---- hw/owi_map.vh ----
// Constants for the fuse-locked wiper serial target; reset clears the fuse lock.
// Assumes inclusion by the target's design files only.
`ifndef OWI_MAP_VH
`define OWI_MAP_VH
`define OWI_ADDR_FIXED 6'h16
`define OWI_WIPER_BITS 6
`define OWI_WIPER_MID 6'h20
`define OWI_INSTR_PROG_BIT 7
`define OWI_FUSE_TIME_MS 400
`define OWI_CLK_KHZ 200000
`define OWI_FUSE_CYCLES (`OWI_FUSE_TIME_MS * `OWI_CLK_KHZ)
`endif

// ---- hw/owi_sync.v ----
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes the reset given is already synchronous to clk on release.
`timescale 1ns/1ps
module owi_sync #(
	parameter RESET_VAL = 1'b1
) (
	input wire clk,
	input wire rst_n,
	input wire d,
	output wire q
);
	reg meta_r;
	reg sync_r;

	// First stage feeds only the second
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end

	assign q = sync_r;
endmodule

// ---- hw/owi_target.v ----
// Two-wire serial target that sets a 64-position wiper with a fuse lock that holds until reset.
// Assumes external pull-ups on the clock and data wires; bus clock is oversampled by CLOCK.
`timescale 1ns/1ps
`include "owi_map.vh"
module owi_target #(
	parameter FUSE_CYCLES = `OWI_FUSE_CYCLES
) (
	input wire CLOCK,
	input wire RSTN,
	input wire SCL_I,
	input wire SDA_I,
	output reg SDA_O,
	output reg SDA_OE,
	input wire ADDRESS_SELECT_PIN,
	output reg [`OWI_WIPER_BITS-1:0] WIPER_REGISTER,
	output reg FUSED,
	output reg FUSE_BUSY
);
	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_INSTR = 3'd2;
	localparam ST_WDATA = 3'd3;
	localparam ST_RDATA = 3'd4;
	localparam ST_RACK = 3'd5;

	reg rst_m_r;
	reg rst_s_r;
	wire rst_n;
	wire scl_s;
	wire sda_s;
	wire strap_s;
	reg scl_d_r;
	reg sda_d_r;
	reg strap_r;
	reg [2:0] state_r;
	reg [2:0] bit_cnt_r;
	reg [7:0] shift_r;
	reg ack_phase_r;
	reg ack_drive_r;
	reg reading_r;
	reg [31:0] fuse_cnt_r;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire [7:0] byte_in;

	// Reset release through two flip-flops
	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end
	assign rst_n = rst_s_r;

	// Pin synchronisers
	owi_sync #(.RESET_VAL(1'b1)) u_scl (.clk(CLOCK), .rst_n(rst_n), .d(SCL_I), .q(scl_s));
	owi_sync #(.RESET_VAL(1'b1)) u_sda (.clk(CLOCK), .rst_n(rst_n), .d(SDA_I), .q(sda_s));
	owi_sync #(.RESET_VAL(1'b0)) u_strap (.clk(CLOCK), .rst_n(rst_n),
		.d(ADDRESS_SELECT_PIN), .q(strap_s));

	// Edge and condition detection on the synchronised lines
	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign byte_in = {shift_r[6:0], sda_s};

	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			strap_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			strap_r <= strap_s;
		end
	end

	// Byte engine: bits taken on clock rise, data line changed on clock fall
	always @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 3'd0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			ack_drive_r <= 1'b0;
			reading_r <= 1'b0;
			SDA_O <= 1'b0;
			SDA_OE <= 1'b0;
			WIPER_REGISTER <= `OWI_WIPER_MID;
			FUSED <= 1'b0;
			FUSE_BUSY <= 1'b0;
			fuse_cnt_r <= 32'd0;
		end else begin
			SDA_O <= 1'b0;
			// Fuse burn timer; the setting is frozen from its start and stays frozen after it ends
			if (FUSE_BUSY) begin
				if (fuse_cnt_r == 32'd0) begin
					FUSE_BUSY <= 1'b0;
					FUSED <= 1'b1;
				end else begin
					fuse_cnt_r <= fuse_cnt_r - 32'd1;
				end
			end
			if (start_det) begin
				state_r <= ST_ADDR;
				bit_cnt_r <= 3'd0;
				ack_phase_r <= 1'b0;
				ack_drive_r <= 1'b0;
				SDA_OE <= 1'b0;
			end else if (stop_det) begin
				state_r <= ST_IDLE;
				ack_phase_r <= 1'b0;
				ack_drive_r <= 1'b0;
				SDA_OE <= 1'b0;
			end else if (scl_fall) begin
				if (ack_phase_r) begin
					// Ninth clock over: release or begin sending
					ack_phase_r <= 1'b0;
					ack_drive_r <= 1'b0;
					if (state_r == ST_RDATA) begin
						SDA_OE <= ~shift_r[7];
					end else begin
						SDA_OE <= 1'b0;
					end
				end else if (ack_drive_r) begin
					ack_phase_r <= 1'b1;
					SDA_OE <= 1'b1;
				end else if (state_r == ST_RDATA) begin
					SDA_OE <= ~shift_r[7];
				end else if (state_r == ST_RACK) begin
					SDA_OE <= 1'b0;
				end
			end else if (scl_rise) begin
				case (state_r)
				ST_ADDR, ST_INSTR, ST_WDATA: begin
					if (!ack_phase_r) begin
						shift_r <= byte_in;
						bit_cnt_r <= bit_cnt_r + 3'd1;
						if (bit_cnt_r == 3'd7) begin
							ack_drive_r <= 1'b1;
							if (state_r == ST_ADDR) begin
								if (byte_in[7:2] == `OWI_ADDR_FIXED && byte_in[1] == strap_r) begin
									reading_r <= byte_in[0];
									state_r <= byte_in[0] ? ST_RDATA : ST_INSTR;
								end else begin
									state_r <= ST_IDLE;
									ack_drive_r <= 1'b0;
								end
							end else if (state_r == ST_INSTR) begin
								state_r <= ST_WDATA;
								if (byte_in[`OWI_INSTR_PROG_BIT] && !FUSED && !FUSE_BUSY) begin
									FUSE_BUSY <= 1'b1;
									fuse_cnt_r <= FUSE_CYCLES - 1;
								end
							end else if (!FUSED && !FUSE_BUSY) begin
								WIPER_REGISTER <= byte_in[`OWI_WIPER_BITS-1:0];
							end
						end
					end
				end
				ST_RDATA: begin
					if (!ack_phase_r) begin
						// Hold here is overridden by the shift below; wiper loaded for sending on the address acknowledge clock rise below
						if (bit_cnt_r == 3'd0 && !reading_r) begin
							shift_r <= shift_r;
						end
					end else begin
						shift_r <= {FUSED, FUSE_BUSY, WIPER_REGISTER};
						bit_cnt_r <= 3'd0;
					end
				end
				ST_RACK: begin
					// Controller acknowledge sampled here
					if (sda_s) begin
						state_r <= ST_IDLE;
					end else begin
						state_r <= ST_RDATA;
						shift_r <= {FUSED, FUSE_BUSY, WIPER_REGISTER};
						bit_cnt_r <= 3'd0;
						reading_r <= 1'b0;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
				endcase
				// Advance read bits after each rise outside the acknowledge
				if (state_r == ST_RDATA && !ack_phase_r && reading_r == 1'b0) begin
					shift_r <= {shift_r[6:0], 1'b0};
					bit_cnt_r <= bit_cnt_r + 3'd1;
					if (bit_cnt_r == 3'd7) begin
						state_r <= ST_RACK;
					end
				end
				if (state_r == ST_RDATA && ack_phase_r) begin
					reading_r <= 1'b0;
				end
			end
		end
	end
endmodule

// ---- tb/owi_mst.sv ----
// Bus controller model: pull-downs only.
// Assumes pull-ups in the bench.
`timescale 1ns/1ps
module owi_mst (
	input wire clk,
	input wire sda,
	output reg scl_pd = 1'b0,
	output reg sda_pd = 1'b0
);
	// Half a bus clock
	task hp;
		repeat (8) @(posedge clk);
	endtask
	// Start or stop: data moves while clock high
	task cond(input st);
		hp;
		sda_pd <= 1'b1;
		hp;
		scl_pd <= st;
		hp;
		sda_pd <= st;
	endtask
	// Nine bits MSB first; a one releases data
	task byte9(input [8:0] tx, output [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			repeat (2) @(posedge clk);
			sda_pd <= ~tx[i];
			hp;
			scl_pd <= 1'b0;
			hp;
			rx[i] = sda;
			scl_pd <= 1'b1;
		end
	endtask
endmodule

// ---- tb/owi_target_chk.sv ----
// Assertions on the wiper target ports.
// Assumes binding to owi_target.
`timescale 1ns/1ps
module owi_target_chk #(parameter FUSE_CYCLES = 20) (
	input wire CLOCK,
	input wire RSTN,
	input wire SCL_I,
	input wire SDA_O,
	input wire SDA_OE,
	input wire FUSED,
	input wire FUSE_BUSY,
	input wire [5:0] WIPER_REGISTER
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	sequence s_burn; FUSE_BUSY ##1 !FUSE_BUSY; endsequence
	property p_mid; $rose(RSTN) |-> WIPER_REGISTER == 6'h20; endproperty
	property p_od; SDA_OE |-> !SDA_O; endproperty
	property p_upd; $changed(WIPER_REGISTER) |-> SCL_I && !FUSED && !FUSE_BUSY; endproperty
	property p_frz; FUSED |=> $stable(WIPER_REGISTER); endproperty
	property p_keep; FUSED |=> FUSED; endproperty
	property p_burn; s_burn |-> ##[0:1] FUSED; endproperty
	property p_oe; $changed(SDA_OE) |-> !SCL_I; endproperty
	property p_hold; $rose(SDA_OE) |=> SDA_OE[*8]; endproperty
	a_mid: assert property (p_mid) else $error("mid");
	a_od: assert property (p_od) else $error("od");
	a_upd: assert property (p_upd) else $error("upd");
	a_frz: assert property (p_frz) else $error("frz");
	a_keep: assert property (p_keep) else $error("keep");
	a_burn: assert property (p_burn) else $error("burn");
	a_oe: assert property (p_oe) else $error("oe");
	a_hold: assert property (p_hold) else $error("hold");
endmodule
bind owi_target owi_target_chk #(.FUSE_CYCLES(FUSE_CYCLES)) u_chk (.CLOCK(CLOCK), .RSTN(RSTN),
	.SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .FUSED(FUSED), .FUSE_BUSY(FUSE_BUSY),
	.WIPER_REGISTER(WIPER_REGISTER));

// ---- tb/owi_target_test.sv ----
// Bench for the wiper target.
// Assumes the controller model and checker.
`timescale 1ns/1ps
module owi_target_test;
	logic CLOCK = 1'b0, RSTN = 1'b0, ADDRESS_SELECT_PIN = 1'b0, a = 1'b0;
	logic [8:0] rx;
	logic [32:0] r, rows [9] = '{33'h0_5800_0505, 33'h0_5A00_1105, 33'h1_5A00_2A2A,
		33'h1_5800_072A, 33'h1_5B00_002A, 33'h1_5B00_002A, 33'h1_5A80_0C2A,
		33'h1_5A00_0C2A, 33'h1_5B00_00AA};
	wire scl_pd, sda_pd, SDA_O, SDA_OE, FUSED, FUSE_BUSY;
	wire [5:0] WIPER_REGISTER;
	wire sda = ~(sda_pd | SDA_OE & ~SDA_O);
	int err_total = 0, checks = 0;
	owi_target #(.FUSE_CYCLES(20)) dut (.CLOCK(CLOCK), .RSTN(RSTN), .SCL_I(~scl_pd), .SDA_I(sda),
		.SDA_O(SDA_O), .SDA_OE(SDA_OE), .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN),
		.WIPER_REGISTER(WIPER_REGISTER), .FUSED(FUSED), .FUSE_BUSY(FUSE_BUSY));
	owi_mst m (.clk(CLOCK), .sda(sda), .scl_pd(scl_pd), .sda_pd(sda_pd));
	// Clock
	initial forever #2.5 CLOCK = ~CLOCK;
	task chk(input [8:0] got, exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %0t %h %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wb(input [7:0] d);
		m.byte9({d, 1'b1}, rx);
		chk(rx[0], !a);
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge CLOCK);
		err_total++;
		give_verdict;
	end
	// Reset, then the table of transfers
	initial begin
		repeat (12) @(posedge CLOCK);
		RSTN <= 1'b1;
		repeat (8) @(posedge CLOCK);
		chk(WIPER_REGISTER, 6'h20);
		for (int k = 0; k < 9; k++) begin
			r = rows[k];
			a = r[31:25] == {6'h16, r[32]};
			ADDRESS_SELECT_PIN <= r[32];
			repeat (8) @(posedge CLOCK);
			m.cond(1'b1);
			wb(r[31:24]);
			if (r[24]) begin
				m.byte9(9'h1FF, rx);
				chk(rx[8:1], r[7:0]);
			end else begin
				wb(r[23:16]);
				wb(r[15:8] + 8'h01);
				wb(r[15:8]);
				chk(WIPER_REGISTER, r[7:0]);
			end
			m.cond(1'b0);
			repeat (40) @(posedge CLOCK);
		end
		// Continued read: controller acknowledge asks for a second byte
		m.cond(1'b1);
		wb(8'h5B);
		m.byte9(9'h1FE, rx);
		chk(rx[8:1], 8'hAA);
		m.byte9(9'h1FF, rx);
		chk(rx[8:1], 8'hAA);
		m.cond(1'b0);
		repeat (40) @(posedge CLOCK);
		// Reset in mid-run recentres the wiper and clears the burn state
		RSTN <= 1'b0;
		repeat (4) @(posedge CLOCK);
		chk(WIPER_REGISTER, 6'h20);
		chk({FUSED, FUSE_BUSY}, 2'b00);
		RSTN <= 1'b1;
		repeat (8) @(posedge CLOCK);
		m.cond(1'b1);
		wb(8'h5A);
		wb(8'h00);
		wb(8'h11);
		chk(WIPER_REGISTER, 6'h11);
		m.cond(1'b0);
		repeat (40) @(posedge CLOCK);
		give_verdict;
	end
endmodule
